// >>> core/supervisor_defines.svh
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// Clock
`define CLK_PERIOD_NS       20
// Hold delay options, typical in microseconds
`define HOLD_FAST_US        1400
`define HOLD_SHORT_US       30000
`define HOLD_STD_US         200000
`define HOLD_LONG_US        1600000
`define HOLD_CYC(us)        (((us) * 1000) / `CLK_PERIOD_NS)
// Manual reset glitch filter, ns
`define GLITCH_NS           100
`define GLITCH_CYC          ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Manual reset qualification, ns (default)
`define QUALIFY_NS          1000
`define QUALIFY_CYC         ((`QUALIFY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Supply dip rejection (default), ns
`define DIP_REJECT_NS       200
`define DIP_REJECT_CYC      ((`DIP_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Hold option codes
`define HOLD_SEL_FAST       2'h0
`define HOLD_SEL_SHORT      2'h1
`define HOLD_SEL_STD        2'h2
`define HOLD_SEL_LONG       2'h3
`define CNT_W               27

`endif

// >>> core/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;

    typedef enum logic [1:0] {
        ST_HOLD    = 2'h0,
        ST_DELAY   = 2'h1,
        ST_RUN     = 2'h2
    } seq_state_e;

    typedef struct packed {
        logic rst_n;
        logic rst;
        logic pullup_en;
    } rst_out_s;

endpackage : supervisor_pkg
`default_nettype wire

// >>> core/supervisor_reset_delay_manual.sv
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_defines.svh"

// How it works
// - The internal pull-up on the open-drain reset is switched off while that output drives low.
// - The hold counter runs only while no brown-out is flagged, so it keeps counting through a supply dip shorter than the rejection time.
// - When the hold counter expires both reset outputs go inactive together.
// - The hold period is one of four build-time options of 1.4 ms, 30 ms, 200 ms or 1.6 s.
// - The standard option, selected by default, is 200 ms.
// - With the standard option reset stays active at least 140 ms after the supply recovers.
// - With the standard option reset is released no later than 280 ms after the supply recovers.
// - Reset is forced once manual reset has been low continuously for the qualification delay.
// - After an accepted manual reset the outputs stay active for the full hold period.
// - Low glitches on manual reset shorter than 100 ns are ignored.
// - The manual reset input has an internal pull-up so an open pin reads inactive.
// - Supply dips shorter than the rejection time cause no reset; longer ones count as brown-out.
// - Reset is asserted on manual reset, watchdog time-out, low supply and during power-up.
// - A supply drop below trip that lasts the rejection time forces reset whatever the counter holds.
module supervisor_reset_delay_manual
    import supervisor_pkg::*;
#(
    parameter logic [1:0]  HOLD_SEL    = `HOLD_SEL_STD,
    parameter int unsigned HOLD_CYCLES = (HOLD_SEL == `HOLD_SEL_FAST)  ? `HOLD_CYC(`HOLD_FAST_US)  :
                                         (HOLD_SEL == `HOLD_SEL_SHORT) ? `HOLD_CYC(`HOLD_SHORT_US) :
                                         (HOLD_SEL == `HOLD_SEL_LONG)  ? `HOLD_CYC(`HOLD_LONG_US)  :
                                                                         `HOLD_CYC(`HOLD_STD_US),
    parameter int unsigned QUAL_CYCLES = `QUALIFY_CYC,
    parameter int unsigned DIP_CYCLES  = `DIP_REJECT_CYC
) (
    input  wire logic clk_sys_i,                 // 50 MHz time base
    input  wire logic arst_n_i,                  // Async reset, power-up
    input  wire logic supply_ok_i,               // Comparator: 1 above trip+margin, 0 below trip
    input  wire logic manual_reset_request_n_i,  // Manual reset pin level
    input  wire logic watchdog_timeout_i,        // Watchdog expiry, same clock
    output logic      rst_n_o,                   // Active-low reset, open-drain drive value
    output logic      rst_n_oe_n_o,              // Low while driving rst_n low
    output logic      rst_n_pullup_en_o,         // Internal pull-up on rst_n
    output logic      rst_o,                     // Active-high complementary reset
    output logic      mr_pullup_en_o             // Internal pull-up on manual reset pin
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [1:0] sup_sync_ff, nxt_sup_sync;
    logic [1:0] mr_sync_ff,  nxt_mr_sync;

    always_comb begin
        nxt_sup_sync = {sup_sync_ff[0], supply_ok_i};
        nxt_mr_sync  = {mr_sync_ff[0], manual_reset_request_n_i};
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sup_sync_ff <= 2'h0;
            mr_sync_ff  <= 2'h3;
        end else begin
            sup_sync_ff <= nxt_sup_sync;
            mr_sync_ff  <= nxt_mr_sync;
        end
    end

    // ****************************************
    // Supply dip rejection and manual filter
    // ****************************************
    // Dip counter must saturate so a short dip never trips, a long one always does
    logic [15:0] dip_cnt_ff, nxt_dip_cnt;
    logic        brown_ff,   nxt_brown;
    logic [15:0] mr_cnt_ff,  nxt_mr_cnt;
    logic        mr_act_ff,  nxt_mr_act;

    always_comb begin
        nxt_dip_cnt = 16'h0000;
        nxt_brown   = brown_ff;
        if (sup_sync_ff[1]) begin
            nxt_brown = 1'b0;
        end else begin
            if (dip_cnt_ff < 16'(DIP_CYCLES)) begin
                nxt_dip_cnt = dip_cnt_ff + 16'h0001;
            end else begin
                nxt_dip_cnt = dip_cnt_ff;
            end
            if (dip_cnt_ff + 16'h0001 >= 16'(DIP_CYCLES)) begin
                nxt_brown = 1'b1;
            end
        end
        nxt_mr_cnt = 16'h0000;
        nxt_mr_act = 1'b0;
        if (!mr_sync_ff[1]) begin
            // Qualification covers the glitch window, whichever is longer
            if (mr_cnt_ff < 16'(QUAL_CYCLES > `GLITCH_CYC ? QUAL_CYCLES : `GLITCH_CYC)) begin
                nxt_mr_cnt = mr_cnt_ff + 16'h0001;
            end else begin
                nxt_mr_cnt = mr_cnt_ff;
                nxt_mr_act = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dip_cnt_ff <= 16'h0000;
            brown_ff   <= 1'b1;
            mr_cnt_ff  <= 16'h0000;
            mr_act_ff  <= 1'b0;
        end else begin
            dip_cnt_ff <= nxt_dip_cnt;
            brown_ff   <= nxt_brown;
            mr_cnt_ff  <= nxt_mr_cnt;
            mr_act_ff  <= nxt_mr_act;
        end
    end

    // ****************************************
    // Hold delay sequencer
    // ****************************************
    logic                cause;
    seq_state_e          state_ff, nxt_state;
    logic [`CNT_W-1:0]   hold_cnt_ff, nxt_hold_cnt;
    rst_out_s            out_ff, nxt_out;
    logic                mr_pu_ff, nxt_mr_pu;

    assign cause = brown_ff | mr_act_ff | watchdog_timeout_i;

    always_comb begin
        nxt_state    = state_ff;
        nxt_hold_cnt = hold_cnt_ff;
        if (cause) begin
            nxt_state    = ST_HOLD;
            nxt_hold_cnt = '0;
        end else begin
            unique case (state_ff)
                ST_HOLD: begin
                    nxt_state    = ST_DELAY;
                    nxt_hold_cnt = '0;
                end
                ST_DELAY: begin
                    if (hold_cnt_ff >= `CNT_W'(HOLD_CYCLES - 1)) begin
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_hold_cnt = hold_cnt_ff + `CNT_W'(1);
                    end
                end
                ST_RUN: begin
                    nxt_state = ST_RUN;
                end
                default: begin
                    nxt_state = ST_HOLD;
                end
            endcase
        end
        nxt_out.rst_n     = (nxt_state == ST_RUN);
        nxt_out.rst       = (nxt_state != ST_RUN);
        nxt_out.pullup_en = (nxt_state == ST_RUN);
        nxt_mr_pu         = 1'b1;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff    <= ST_HOLD;
            hold_cnt_ff <= '0;
            out_ff      <= '{rst_n: 1'b0, rst: 1'b1, pullup_en: 1'b0};
            mr_pu_ff    <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            hold_cnt_ff <= nxt_hold_cnt;
            out_ff      <= nxt_out;
            mr_pu_ff    <= nxt_mr_pu;
        end
    end

    assign rst_n_o           = out_ff.rst_n;
    assign rst_n_oe_n_o      = out_ff.rst_n;
    assign rst_n_pullup_en_o = out_ff.pullup_en;
    assign rst_o             = out_ff.rst;
    assign mr_pullup_en_o    = mr_pu_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_pullup_off_low: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !rst_n_o |-> !rst_n_pullup_en_o && !rst_n_oe_n_o) else $error("pull-up on while driving low");
    a_outputs_compl: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rst_o == !rst_n_o) else $error("reset outputs not complementary");
    a_no_count_cause: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cause |=> hold_cnt_ff == '0 && state_ff == ST_HOLD) else $error("counter ran under a cause");
    a_brown_forces: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(brown_ff) |-> ##2 !rst_n_o) else $error("brown-out did not force reset");
    a_mr_forces: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(mr_act_ff) |-> ##2 rst_o) else $error("manual reset did not force reset");
    a_glitch_reject: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(mr_act_ff) |-> !$past(mr_sync_ff[1], 5) && !$past(mr_sync_ff[1], 1)) else $error("short glitch accepted");
    a_release_time: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(rst_n_o) |-> $past(state_ff, 1) == ST_DELAY && $past(hold_cnt_ff, 1) == `CNT_W'(HOLD_CYCLES - 1))
        else $error("release not at hold expiry");
    a_supply_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (state_ff == ST_DELAY && hold_cnt_ff != '0) |-> !$past(brown_ff)) else $error("counted while supply low");
    a_mr_pullup: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        mr_pullup_en_o) else $error("manual pull-up off");

endmodule : supervisor_reset_delay_manual

`default_nettype wire

// >>> testbench/host_button_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_button_model (
    input  wire logic clk_i,            // Bench clock
    input  wire logic press_i,          // Button held down
    input  wire logic mr_pullup_en_i,   // Pull-up on button line
    input  wire logic rst_drive_i,      // Reset drive value
    input  wire logic rst_oe_n_i,       // Low while reset driven
    input  wire logic rst_pullup_en_i,  // Pull-up on reset line
    output logic      mr_pin_o,         // Button line level
    output logic      host_rst_n_o      // Reset level the host sees
);
    logic float_ff = 1'b0;

    always_ff @(posedge clk_i) float_ff <= ~float_ff;
    // Button only pulls down; a released line rests on the pull-up
    assign mr_pin_o = press_i ? 1'b0 : (mr_pullup_en_i ? 1'b1 : float_ff);
    // Undriven line without pull-up wanders instead of keeping its old value
    assign host_rst_n_o = !rst_oe_n_i ? rst_drive_i : (rst_pullup_en_i ? 1'b1 : float_ff);
endmodule : host_button_model
`default_nettype wire

// >>> testbench/supervisor_reset_delay_manual_tb.sv
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_delay_manual_tb;
    import supervisor_pkg::*;
    localparam int HOLD = 20;
    logic clk_sys_i, arst_n_i, supply_ok_i, press, wdt;
    logic mr_pin, host_rst_n, rst_n_o, oe_n, pu_en, rst_o, mr_pu;
    int   fail_count = 0, n_tests = 0, cyc = 0;

    // ****************
    // Design and far side
    // ****************
    supervisor_reset_delay_manual #(.HOLD_CYCLES(HOLD)) supervisor_reset_delay_manual_inst (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supply_ok_i(supply_ok_i),
        .manual_reset_request_n_i(mr_pin), .watchdog_timeout_i(wdt), .rst_n_o(rst_n_o),
        .rst_n_oe_n_o(oe_n), .rst_n_pullup_en_o(pu_en), .rst_o(rst_o), .mr_pullup_en_o(mr_pu));
    host_button_model host_button_model_inst (
        .clk_i(clk_sys_i), .press_i(press), .mr_pullup_en_i(mr_pu), .rst_drive_i(rst_n_o),
        .rst_oe_n_i(oe_n), .rst_pullup_en_i(pu_en), .mr_pin_o(mr_pin), .host_rst_n_o(host_rst_n));

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    // ****************
    // Shared tasks
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic release_time(output int n);
        n = 0;
        while (host_rst_n !== 1'b1 && n < 2000) begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask : release_time

    // ****************
    // Scenarios
    // ****************
    task automatic t_powerup();
        int n;
        check("rst_at_powerup", rst_o, 1'b1);
        check("pullup_while_low", pu_en, 1'b0);
        check("mr_pullup", mr_pu, 1'b1);
        repeat (30) @(negedge clk_sys_i);
        check("held_while_supply_low", rst_o, 1'b1);
        @(posedge clk_sys_i) supply_ok_i <= 1'b1;
        release_time(n);
        check("hold_min", n >= HOLD, 1'b1);
        check("hold_max", n <= HOLD + 10, 1'b1);
        check("rst_inactive", rst_o, 1'b0);
        check("oe_released", oe_n, 1'b1);
        check("pullup_back", pu_en, 1'b1);
    endtask : t_powerup

    // Kind 0 supply dip, 1 button press, 2 watchdog pulse
    task automatic t_cause(input int kind, input int len, input logic exp_rst);
        int   n;
        logic hit;
        @(posedge clk_sys_i);
        if (kind == 0) supply_ok_i <= 1'b0;
        else if (kind == 1) press <= 1'b1;
        else wdt <= 1'b1;
        repeat (len) @(posedge clk_sys_i);
        supply_ok_i <= 1'b1;
        press       <= 1'b0;
        wdt         <= 1'b0;
        hit = 1'b0;
        repeat (8) begin
            @(negedge clk_sys_i);
            if (rst_o === 1'b1) hit = 1'b1;
        end
        check("reset_seen", hit, exp_rst);
        if (exp_rst) begin
            check("both_active", rst_n_o, 1'b0);
            release_time(n);
            check("restart_min", n + 8 >= HOLD, 1'b1);
            check("restart_max", n + 8 <= HOLD + 12, 1'b1);
            check("rst_cleared", rst_o, 1'b0);
        end
        repeat (4) @(negedge clk_sys_i);
    endtask : t_cause

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        arst_n_i    = 1'b0;
        supply_ok_i = 1'b0;
        press       = 1'b0;
        wdt         = 1'b0;
        repeat (4) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(negedge clk_sys_i);
        t_powerup();
        t_cause(0, 5, 1'b0);
        t_cause(0, 30, 1'b1);
        t_cause(1, 3, 1'b0);
        t_cause(1, 40, 1'b0);
        t_cause(1, 70, 1'b1);
        t_cause(2, 1, 1'b1);
        results();
    end
endmodule : supervisor_reset_delay_manual_tb
`default_nettype wire
